// ==== region_guard.sv ====
// Region protection unit: region storage, access checking and fault signalling.
// How it works
// RULE1: Protection off: default map, never a fault.
// RULE2: Protection on: permission breach in the applicable region raises a fault.
// RULE3: Privileged-default set: unmatched privileged access uses default map, no fault.
// RULE4: Software defines a region or selects privileged-default before enabling.
// RULE5: Fault-handler option clear: checks suspended in hard-fault or NMI handlers.
// RULE6: Software can read the constant total count of regions.
// RULE7: Up to eight independently configurable regions.
// RULE8: Clearing enable stops checks but keeps base and attributes stored.
// RULE9: Setting enable applies stored rules to matching accesses at once.
// RULE10: Read-back gives base and full attributes, enable included, same format.
// RULE11: Software aligns each base to the region size.
// RULE12: Size code is a power of two from 32 bytes to 4 GB.
// RULE13: Execute-forbidden regions fault instruction fetches.
// RULE14: Six read/write codes set privileged and user access separately.
// RULE15: Eight sub-regions each with a disable bit leaving a hole.
// RULE16: Sub-region disables act only for regions of 256 bytes or more.
// RULE17: Attribute enable flag set or clear leaves region active or inactive.
// RULE18: Software disables a region before changing it.
// RULE19: Highest-numbered matching enabled region wins.
// RULE20: A software region number selects which region is written or read.
`timescale 1ns/1ps
`default_nettype none

module region_guard
  import region_guard_pkg::*;
#(
  parameter int unsigned NUM_REGIONS = NUM_REGIONS_DEF
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire global_cfg_t         cfg,
  input  wire logic [2:0]          region_sel,
  input  wire logic                base_wr,
  input  wire logic [ADDR_W-1:0]   base_wdata,
  input  wire logic                attr_wr,
  input  wire logic [ATTR_W-1:0]   attr_wdata,
  input  wire logic                region_on_set,
  input  wire logic                region_off_set,
  input  wire mem_access_t         access,
  output logic [ADDR_W-1:0]        base_rdata,
  output logic [ATTR_W-1:0]        attr_rdata,
  output logic [3:0]               region_count,
  output logic                     access_done,
  output logic                     mem_fault,
  output logic                     default_map_used
);

  localparam int unsigned IDX_W = 3;

  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_sn = rst_s2_q;

  // Region storage.
  logic [ADDR_W-1:0] base_q [NUM_REGIONS];
  logic [ADDR_W-1:0] base_d [NUM_REGIONS];
  region_attr_t      attr_q [NUM_REGIONS];
  region_attr_t      attr_d [NUM_REGIONS];

  function automatic region_attr_t unpack_attr(input logic [ATTR_W-1:0] w);
    region_attr_t a;
    a.region_on_flag    = w[ATTR_ON_BIT];
    a.size_code         = w[ATTR_SIZE_LSB +: 5];
    a.subregion_off_bit = w[ATTR_SUB_LSB +: 8];
    a.perm              = rw_perm_t'(w[ATTR_PERM_LSB +: 3]);
    a.execute_forbidden = w[ATTR_XN_BIT];
    if (a.size_code < SIZE_MIN_CODE) begin
      a.size_code = SIZE_MIN_CODE;  // RULE12
    end
    return a;
  endfunction : unpack_attr

  function automatic logic [ATTR_W-1:0] pack_attr(input region_attr_t a);
    logic [ATTR_W-1:0] w;
    w                       = '0;
    w[ATTR_ON_BIT]          = a.region_on_flag;
    w[ATTR_SIZE_LSB +: 5]   = a.size_code;
    w[ATTR_SUB_LSB +: 8]    = a.subregion_off_bit;
    w[ATTR_PERM_LSB +: 3]   = a.perm;
    w[ATTR_XN_BIT]          = a.execute_forbidden;
    return w;
  endfunction : pack_attr

  always_comb begin
    for (int i = 0; i < NUM_REGIONS; i++) begin
      base_d[i] = base_q[i];
      attr_d[i] = attr_q[i];
      if (region_sel == IDX_W'(i)) begin  // RULE20
        if (base_wr) begin
          base_d[i] = base_wdata;
        end
        if (attr_wr) begin
          attr_d[i] = unpack_attr(attr_wdata);  // RULE17
        end else if (region_on_set) begin
          attr_d[i].region_on_flag = 1'b1;  // RULE9
        end else if (region_off_set) begin
          attr_d[i].region_on_flag = 1'b0;  // RULE8
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
        base_q[i] <= '0;
        attr_q[i] <= '{execute_forbidden: 1'b0, perm: PERM_NO_NO,
                       subregion_off_bit: 8'h00, size_code: SIZE_MIN_CODE,
                       region_on_flag: 1'b0};
      end
    end else begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
        base_q[i] <= base_d[i];
        attr_q[i] <= attr_d[i];
      end
    end
  end

  // Region hit: the base is compared above the size bits, so a misaligned base
  // simply acts as if its low bits were zero.
  function automatic logic region_hit(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] b,
                                      input region_attr_t r);
    logic [ADDR_W:0] mask;
    logic [4:0]      sh;
    logic [2:0]      sub;
    logic            in;
    // The shift amount is six bits wide so the 4 GB code does not wrap to zero.
    mask = ({(ADDR_W+1){1'b1}} << ({1'b0, r.size_code} + 6'h01));  // RULE12
    in   = ((a & mask[ADDR_W-1:0]) == (b & mask[ADDR_W-1:0]));  // RULE11
    sh   = r.size_code + 5'h01 - SUB_SHIFT;
    sub  = 3'(a >> sh);
    if (r.size_code >= SIZE_SUB_MIN && r.subregion_off_bit[sub]) begin  // RULE15 RULE16
      in = 1'b0;
    end
    return in && r.region_on_flag;  // RULE8 RULE9
  endfunction : region_hit

  function automatic logic perm_ok(input rw_perm_t p, input logic priv,
                                   input logic wr);
    logic ok;
    case (p)  // RULE14
      PERM_NO_NO: ok = 1'b0;
      PERM_RW_NO: ok = priv;
      PERM_RW_RO: ok = priv || !wr;
      PERM_RW_RW: ok = 1'b1;
      PERM_RO_NO: ok = priv && !wr;
      PERM_RO_RO: ok = !wr;
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction : perm_ok

  logic         any_hit;
  region_attr_t win_attr;
  logic         checking;
  logic         fault_c;
  logic         dflt_c;

  always_comb begin
    any_hit  = 1'b0;
    win_attr = attr_q[0];
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (region_hit(access.addr, base_q[i], attr_q[i])) begin
        any_hit  = 1'b1;
        win_attr = attr_q[i];  // RULE19
      end
    end
    checking = cfg.enable &&
               (!access.fault_handler || cfg.protect_in_fault_handlers);  // RULE1 RULE5
    fault_c  = 1'b0;
    dflt_c   = 1'b1;
    if (checking) begin
      if (any_hit) begin
        dflt_c  = 1'b0;
        fault_c = (access.fetch && win_attr.execute_forbidden) ||  // RULE13
                  (!access.fetch &&
                   !perm_ok(win_attr.perm, access.privileged, access.write));  // RULE2
      end else if (access.privileged && cfg.privileged_default_map) begin
        dflt_c  = 1'b1;  // RULE3
      end else begin
        dflt_c  = 1'b0;
        fault_c = 1'b1;  // RULE2
      end
    end
  end

  logic              done_q;
  logic              fault_q;
  logic              dflt_q;
  logic [ADDR_W-1:0] base_rd_q;
  logic [ATTR_W-1:0] attr_rd_q;

  always_ff @(posedge ref_clk or negedge rst_sn) begin
    if (!rst_sn) begin
      done_q    <= 1'b0;
      fault_q   <= 1'b0;
      dflt_q    <= 1'b0;
      base_rd_q <= '0;
      attr_rd_q <= '0;
    end else begin
      done_q    <= access.valid;
      fault_q   <= access.valid && fault_c;
      dflt_q    <= access.valid && dflt_c;
      base_rd_q <= base_q[region_sel];  // RULE10 RULE20
      attr_rd_q <= pack_attr(attr_q[region_sel]);  // RULE10
    end
  end

  assign base_rdata       = base_rd_q;
  assign attr_rdata       = attr_rd_q;
  assign region_count     = 4'(NUM_REGIONS);  // RULE6 RULE7
  assign access_done      = done_q;
  assign mem_fault        = fault_q;
  assign default_map_used = dflt_q;

  AST_OFF_NO_FAULT: assert property (@(posedge ref_clk) disable iff (!rst_sn)  // RULE1
    access.valid && !cfg.enable |=> !mem_fault && default_map_used)
    else $error("Fault raised while protection is off.");

  AST_NO_REGION_FAULT: assert property (@(posedge ref_clk) disable iff (!rst_sn)  // RULE2
    access.valid && checking && !any_hit && !access.privileged |=> mem_fault)
    else $error("Unmatched user access did not fault.");

  AST_PRIV_DEFAULT: assert property (@(posedge ref_clk) disable iff (!rst_sn)  // RULE3
    access.valid && checking && !any_hit && access.privileged
      && cfg.privileged_default_map |=> !mem_fault && default_map_used)
    else $error("Privileged default map not applied.");

  AST_HANDLER_BYPASS: assert property (@(posedge ref_clk) disable iff (!rst_sn)  // RULE5
    access.valid && access.fault_handler && !cfg.protect_in_fault_handlers
      |=> !mem_fault)
    else $error("Fault raised inside a handler with checks suspended.");

  AST_XN_FETCH: assert property (@(posedge ref_clk) disable iff (!rst_sn)  // RULE13
    access.valid && checking && any_hit && access.fetch
      && win_attr.execute_forbidden |=> mem_fault)
    else $error("Fetch from execute-forbidden region did not fault.");

  // Read-back lags storage by one edge, so the value latched at the clear edge is
  // the old state and the one latched an edge later is the new state.
  AST_OFF_KEEPS: assert property (@(posedge ref_clk) disable iff (!rst_sn)  // RULE8
    region_off_set && !attr_wr && !base_wr ##1 $stable(region_sel) && !attr_wr
      && !region_on_set |=> attr_rdata[ATTR_W-1:1] == $past(attr_rdata[ATTR_W-1:1])
      && !attr_rdata[ATTR_ON_BIT])
    else $error("Disabling a region altered its stored attributes.");

  AST_ON_READBACK: assert property (@(posedge ref_clk) disable iff (!rst_sn)  // RULE9
    region_on_set && !attr_wr && $stable(region_sel) ##1 $stable(region_sel)
      |=> attr_rdata[ATTR_ON_BIT])
    else $error("Enable not visible in read-back.");

  AST_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_sn)  // RULE6
    region_count == 4'(NUM_REGIONS) && region_count != 4'h0)
    else $error("Region count wrong.");

  AST_FULL_PERM_OK: assert property (@(posedge ref_clk) disable iff (!rst_sn)  // RULE14
    access.valid && checking && any_hit && !access.fetch
      && win_attr.perm == PERM_RW_RW |=> !mem_fault)
    else $error("Full access region faulted.");

endmodule : region_guard

`default_nettype wire

// ==== region_guard_pkg.sv ====
// Shared constants, encodings and carrier types for the region protection unit.
package region_guard_pkg;

  localparam int unsigned NUM_REGIONS_DEF = 8;
  localparam int unsigned ADDR_W          = 32;
  localparam int unsigned SUB_COUNT       = 8;

  // Size code n selects a region of 2**(n+1) bytes; 4 is 32 bytes, 31 is 4 GB.
  localparam logic [4:0] SIZE_MIN_CODE    = 5'h04;
  localparam logic [4:0] SIZE_MAX_CODE    = 5'h1F;
  localparam logic [4:0] SIZE_SUB_MIN     = 5'h07;  // 256 bytes
  localparam logic [4:0] SUB_SHIFT        = 5'h03;  // eight sub-regions

  // Attribute word layout, identical for programming and read-back.
  localparam int unsigned ATTR_W          = 32;
  localparam int unsigned ATTR_ON_BIT     = 0;
  localparam int unsigned ATTR_SIZE_LSB   = 1;
  localparam int unsigned ATTR_SUB_LSB    = 8;
  localparam int unsigned ATTR_PERM_LSB   = 24;
  localparam int unsigned ATTR_XN_BIT     = 28;

  typedef enum logic [2:0] {
    PERM_NO_NO = 3'h0,
    PERM_RW_NO = 3'h1,
    PERM_RW_RO = 3'h2,
    PERM_RW_RW = 3'h3,
    PERM_RO_NO = 3'h5,
    PERM_RO_RO = 3'h6
  } rw_perm_t;

  typedef struct packed {
    logic             execute_forbidden;
    rw_perm_t         perm;
    logic [7:0]       subregion_off_bit;
    logic [4:0]       size_code;
    logic             region_on_flag;
  } region_attr_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic              fetch;
    logic              privileged;
    logic              fault_handler;
  } mem_access_t;

  typedef struct packed {
    logic             privileged_default_map;
    logic             protect_in_fault_handlers;
    logic             enable;
  } global_cfg_t;

endpackage : region_guard_pkg

// ==== core_model.sv ====
// Processor-side model that issues memory accesses to the protection unit.
`timescale 1ns/1ps
`default_nettype none
module core_model
  import region_guard_pkg::*;
(
  input  wire logic   ref_clk,
  output var mem_access_t access
);
  initial access = '0;
  // One access per falling edge; back-to-back calls keep valid high.
  task automatic issue(input mem_access_t a);
    access = a;
    access.valid = 1'b1;
    @(negedge ref_clk);
  endtask : issue
  // A released bus shows the inverted address so a stale copy never looks valid.
  // One idle cycle follows, so valid never changes twice in one time step.
  task automatic release_bus();
    access.valid = 1'b0;
    access.addr  = ~access.addr;
    @(negedge ref_clk);
  endtask : release_bus
endmodule : core_model
`default_nettype wire

// ==== tb_memory_region_protection.sv ====
// Self-checking bench for the region protection unit.
`timescale 1ns/1ps
`default_nettype none
module tb_memory_region_protection;
  import region_guard_pkg::*;
  logic              ref_clk, rst_n, base_wr, attr_wr, region_on_set, region_off_set;
  global_cfg_t       cfg;
  logic [2:0]        region_sel;
  logic [ADDR_W-1:0] base_wdata, base_rdata;
  logic [ATTR_W-1:0] attr_wdata, attr_rdata;
  logic [3:0]        region_count;
  logic              access_done, mem_fault, default_map_used;
  mem_access_t       access;
  logic [31:0]       sb [8];
  region_attr_t      sa [8];
  logic [1:0]        expq [$];
  int                fails, total_checks;
  localparam logic [4:0] SIZES [8] = '{5'h04, 5'h07, 5'h05, 5'h1F, 5'h09, 5'h0C, 5'h07, 5'h10};
  localparam rw_perm_t PERMS [6] = '{PERM_NO_NO, PERM_RW_NO, PERM_RW_RO, PERM_RW_RW, PERM_RO_NO,
                                     PERM_RO_RO};

  region_guard #(.NUM_REGIONS(8)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg),
    .region_sel(region_sel), .base_wr(base_wr), .base_wdata(base_wdata), .attr_wr(attr_wr),
    .attr_wdata(attr_wdata), .region_on_set(region_on_set), .region_off_set(region_off_set),
    .access(access), .base_rdata(base_rdata), .attr_rdata(attr_rdata),
    .region_count(region_count), .access_done(access_done), .mem_fault(mem_fault),
    .default_map_used(default_map_used));
  core_model u_core (.ref_clk(ref_clk), .access(access));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic cmp_res(input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_res

  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_word

  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] attr_word(input region_attr_t r);
    attr_word = '0;
    attr_word[ATTR_ON_BIT] = r.region_on_flag;
    attr_word[ATTR_SIZE_LSB +: 5] = r.size_code;
    attr_word[ATTR_SUB_LSB +: 8] = r.subregion_off_bit;
    attr_word[ATTR_PERM_LSB +: 3] = r.perm;
    attr_word[ATTR_XN_BIT] = r.execute_forbidden;
  endfunction : attr_word

  // Result as {fault, default map}; written from the rules, not from the design.
  function automatic logic [1:0] expect_res(input mem_access_t a);
    int       hit;
    int       n;
    logic     ok;
    rw_perm_t p;
    hit = -1;
    if (!cfg.enable || (a.fault_handler && !cfg.protect_in_fault_handlers)) return 2'h1;
    for (int i = 0; i < 8; i++) begin
      n = int'(sa[i].size_code);
      if (sa[i].region_on_flag && ((64'(a.addr ^ sb[i]) >> (n + 1)) == 0) &&
          (n < 7 || !sa[i].subregion_off_bit[3'(a.addr >> (n - 2))])) hit = i;
    end
    if (hit < 0) return (a.privileged && cfg.privileged_default_map) ? 2'h1 : 2'h2;
    if (a.fetch) return {sa[hit].execute_forbidden, 1'b0};
    p = sa[hit].perm;
    if (a.privileged) ok = a.write ? (p inside {PERM_RW_NO, PERM_RW_RO, PERM_RW_RW}) : (p != PERM_NO_NO);
    else ok = a.write ? (p == PERM_RW_RW) : (p inside {PERM_RW_RO, PERM_RW_RW, PERM_RO_RO});
    return {!ok, 1'b0};
  endfunction : expect_res

  task automatic write_region(input int i);
    region_sel = 3'(i);
    base_wr    = 1'b1;
    base_wdata = sb[i];
    @(negedge ref_clk);
    base_wr    = 1'b0;
    attr_wr    = 1'b1;
    attr_wdata = attr_word(sa[i]);
    @(negedge ref_clk);
    attr_wr    = 1'b0;
  endtask : write_region

  task automatic readback(input int i);
    region_sel = 3'(i);
    repeat (3) @(negedge ref_clk);
    cmp_word(sb[i], base_rdata);
    cmp_word(attr_word(sa[i]), attr_rdata);
  endtask : readback

  // The region number settles one cycle ahead of the strobe, as software would.
  task automatic set_on(input int i, input logic on);
    region_sel     = 3'(i);
    @(negedge ref_clk);
    region_on_set  = on;
    region_off_set = !on;
    @(negedge ref_clk);
    region_on_set  = 1'b0;
    region_off_set = 1'b0;
    sa[i].region_on_flag = on;
  endtask : set_on

  // Addresses land mostly inside a chosen region so overlaps and holes are hit.
  task automatic run_accesses(input int n);
    mem_access_t a;
    int          r;
    for (int k = 0; k < n; k++) begin
      r = $urandom_range(7);
      a = 38'({$urandom, $urandom});
      if ($urandom_range(3) != 0)
        a.addr = sb[r] + 32'(64'($urandom) % (64'h1 << (sa[r].size_code + 6'h01)));
      expq.push_back(expect_res(a));
      u_core.issue(a);
    end
    u_core.release_bus();
  endtask : run_accesses

  always @(negedge ref_clk) begin
    if (access_done === 1'b1) begin
      cmp_res(expq.size() > 0 ? expq.pop_front() : 2'bxx, {mem_fault, default_map_used});
    end
  end

  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    void'($urandom(10293));
    {fails, total_checks} = '0;
    {rst_n, base_wr, attr_wr, region_on_set, region_off_set} = '0;
    {cfg, region_sel, base_wdata, attr_wdata} = '0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    cmp_word(32'h0000_0008, 32'(region_count));
    // Regions are written while no access runs.
    for (int i = 0; i < 8; i++) begin
      sa[i] = 18'($urandom);
      sa[i].size_code = SIZES[i];
      sa[i].perm = PERMS[i % 6];
      sb[i] = 32'(64'($urandom) & ~((64'h1 << (SIZES[i] + 6'h01)) - 64'h1));
      write_region(i);
      readback(i);
    end
    for (int c = 0; c < 8; c++) begin
      cfg = global_cfg_t'(3'(c));
      run_accesses(40);
    end
    cfg = global_cfg_t'(3'h1);
    for (int k = 0; k < 2; k++) begin
      set_on(6, 1'(k));
      readback(6);
      run_accesses(60);
    end
    repeat (3) @(negedge ref_clk);
    cmp_word(32'h0000_0000, 32'(expq.size()));
    print_verdict();
  end
endmodule : tb_memory_region_protection
`default_nettype wire
